// >>> logic/rbl_consts.vh
// Register offsets, field positions, reset values and timing counts
`ifndef RBL_CONSTS_VH
`define RBL_CONSTS_VH
`define RBL_IDX_TEMP_HIGH 8'h13
`define RBL_IDX_TEMP_LOW 8'h14
`define RBL_IDX_CUR_HIGH 8'h15
`define RBL_IDX_CUR_LOW 8'h16
`define RBL_IDX_PWM_HIGH 8'h17
`define RBL_IDX_PWM_LOW 8'h18
`define RBL_IDX_NVM_CTRL 8'h19
`define RBL_IDX_UNLOCK 8'h1A
`define RBL_IDX_CFG_FIRST 8'h60
`define RBL_IDX_CFG_LAST 8'h78
`define RBL_CFG_COUNT 25
`define RBL_NVM_CTRL_RESET 8'h80
`define RBL_PWM_RESET 16'h0000
`define RBL_BIT_IDLE 7
`define RBL_BIT_PROGRAM 1
`define RBL_BIT_LOAD 0
`define RBL_KEY_FIRST 8'h08
`define RBL_KEY_SECOND 8'hBA
`define RBL_KEY_THIRD 8'hEF
`define RBL_CLK_HZ 10000000
`define RBL_PROG_TIME_US 200000
`define RBL_LOAD_TIME_US 1000
`define RBL_PROG_CYCLES ((`RBL_PROG_TIME_US / 1000) * (`RBL_CLK_HZ / 1000))
`define RBL_LOAD_CYCLES ((`RBL_LOAD_TIME_US / 1000) * (`RBL_CLK_HZ / 1000))
`define RBL_RESP_OKAY 2'b00
`define RBL_RESP_SLVERR 2'b10
`endif

// >>> logic/rbl_unlock.v
// Unlock code sequence detector
`timescale 1ns/1ps
module rbl_unlock
(
	input wire aclk,
	input wire aresetn,
	input wire key_wr,
	input wire [7:0] key_data,
	output wire unlocked
);
`include "rbl_consts.vh"
	localparam ST_IDLE = 4'b0001;
	localparam ST_ONE = 4'b0010;
	localparam ST_TWO = 4'b0100;
	localparam ST_OPEN = 4'b1000;
	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	always @*
	begin
		nxt_state = state_ff;
		if (key_wr)
		begin
			case (state_ff)
				ST_IDLE: nxt_state = (key_data == `RBL_KEY_FIRST) ? ST_ONE : ST_IDLE;
				ST_ONE: nxt_state = (key_data == `RBL_KEY_SECOND) ? ST_TWO : ST_IDLE;
				ST_TWO: nxt_state = (key_data == `RBL_KEY_THIRD) ? ST_OPEN : ST_IDLE;
				ST_OPEN: nxt_state = ST_IDLE;
				default: nxt_state = ST_IDLE;
			endcase
		end
	end
	always @(posedge aclk)
	begin
		if (!aresetn)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end
	assign unlocked = state_ff[3];
endmodule

// >>> logic/rbl_nvm_seq.v
// Program and load operation timer with busy indication
`timescale 1ns/1ps
`include "rbl_consts.vh"
module rbl_nvm_seq
#(
	parameter PROG_CYCLES = `RBL_PROG_CYCLES,
	parameter LOAD_CYCLES = `RBL_LOAD_CYCLES
)
(
	input wire aclk,
	input wire aresetn,
	input wire start_prog,
	input wire start_load,
	output wire busy,
	output reg copy_to_array,
	output reg copy_to_shadow
);
	reg [21:0] cnt_ff;
	reg busy_ff;
	reg prog_ff;
	assign busy = busy_ff;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_ff <= 22'h000000;
			busy_ff <= 1'b0;
			prog_ff <= 1'b0;
			copy_to_array <= 1'b0;
			copy_to_shadow <= 1'b0;
		end
		else
		begin
			copy_to_array <= 1'b0;
			copy_to_shadow <= 1'b0;
			if (!busy_ff && start_prog)
			begin
				busy_ff <= 1'b1;
				prog_ff <= 1'b1;
				cnt_ff <= PROG_CYCLES[21:0] - 22'h000001;
			end
			else if (!busy_ff && start_load)
			begin
				busy_ff <= 1'b1;
				prog_ff <= 1'b0;
				cnt_ff <= LOAD_CYCLES[21:0] - 22'h000001;
			end
			else if (busy_ff)
			begin
				if (cnt_ff == 22'h000000)
				begin
					busy_ff <= 1'b0;
					copy_to_array <= prog_ff;
					copy_to_shadow <= !prog_ff;
				end
				else
					cnt_ff <= cnt_ff - 22'h000001;
			end
		end
	end
endmodule

// >>> logic/rbl_top.v
// AXI4-Lite readback latch and nonvolatile configuration control
// Functional notes
// - Thermal high bits at 0x13, read latches
// - Thermal low byte from latched value
// - Current high read latches current and PWM
// - Current readback split over 0x15, 0x16
// - PWM readback 0x17 high, 0x18 low
// - Control bit 7 idle flag, reset 0x80
// - Program bit copies shadow to array
// - Load bit copies array to shadow
// - Key 08, BA, EF unlocks control
// - Any key write with byte lane 0 strobed while unlocked relocks
`timescale 1ns/1ps
`include "rbl_consts.vh"
module rbl_top
#(
	parameter PROG_CYCLES = `RBL_PROG_CYCLES,
	parameter LOAD_CYCLES = `RBL_LOAD_CYCLES,
	parameter CFG_COUNT = `RBL_CFG_COUNT
)
(
	input wire aclk,
	input wire aresetn,
	input wire [10:0] die_thermal,
	input wire [11:0] drive_current,
	input wire [15:0] drive_pwm,
	input wire [9:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [9:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire nvm_busy,
	output wire unlocked
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	reg [38:0] sync1_ff;
	reg [38:0] sync2_ff;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_ff <= 39'h0000000000;
			sync2_ff <= 39'h0000000000;
		end
		else
		begin
			sync1_ff <= {die_thermal, drive_current, drive_pwm};
			sync2_ff <= sync1_ff;
		end
	end
	// ----------------------------------------------------------------
	// Word settle stage
	// ----------------------------------------------------------------
	// Bits of one word may resolve on different edges; pass a word
	// only once two samples agree, else keep the last steady one
	reg [38:0] sync3_ff;
	reg [38:0] settled_ff;
	wire word_steady = (sync2_ff == sync3_ff);
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync3_ff <= 39'h0000000000;
			settled_ff <= 39'h0000000000;
		end
		else
		begin
			sync3_ff <= sync2_ff;
			if (word_steady)
				settled_ff <= sync3_ff;
		end
	end
	wire [10:0] thermal_live = settled_ff[38:28];
	wire [11:0] current_live = settled_ff[27:16];
	wire [15:0] pwm_live = settled_ff[15:0];
	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	reg [9:0] awaddr_ff;
	reg aw_held_ff;
	reg [7:0] wdata_ff;
	reg wlane_ff;
	reg w_held_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	wire wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
	wire [7:0] wr_idx = awaddr_ff[9:2];
	wire wr_cfg = (wr_idx >= `RBL_IDX_CFG_FIRST) && (wr_idx <= `RBL_IDX_CFG_LAST);
	wire wr_ctrl = wr_idx == `RBL_IDX_NVM_CTRL;
	wire wr_key = wr_idx == `RBL_IDX_UNLOCK;
	wire wr_ok = wr_cfg || wr_ctrl || wr_key;
	wire key_wr = wr_go && wr_key && wlane_ff;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_ff <= 10'h000;
			aw_held_ff <= 1'b0;
			wdata_ff <= 8'h00;
			wlane_ff <= 1'b0;
			w_held_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RBL_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_ff <= s_axi_awaddr;
				aw_held_ff <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_ff <= s_axi_wdata[7:0];
				wlane_ff <= s_axi_wstrb[0];
				w_held_ff <= 1'b1;
			end
			if (wr_go)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? `RBL_RESP_OKAY : `RBL_RESP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// Unlock and operation sequencer
	// ----------------------------------------------------------------
	wire copy_to_array;
	wire copy_to_shadow;
	rbl_unlock u_unlock
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.key_wr(key_wr),
		.key_data(wdata_ff),
		.unlocked(unlocked)
	);
	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	// Writes accepted only while unlocked
	wire ctrl_wr = wr_go && wr_ctrl && wlane_ff && unlocked;
	wire cfg_wr = wr_go && wr_cfg && wlane_ff && unlocked;
	localparam [7:0] CTRL_RESET = `RBL_NVM_CTRL_RESET;
	reg [1:0] cmd_ff;
	always @(posedge aclk)
	begin
		if (!aresetn)
			cmd_ff <= CTRL_RESET[1:0];
		else if (ctrl_wr)
			cmd_ff <= {wdata_ff[`RBL_BIT_PROGRAM], wdata_ff[`RBL_BIT_LOAD]};
	end
	// Start on rising command bit
	wire start_prog = ctrl_wr && wdata_ff[`RBL_BIT_PROGRAM] && !cmd_ff[1];
	wire start_load = ctrl_wr && wdata_ff[`RBL_BIT_LOAD] && !cmd_ff[0];
	rbl_nvm_seq #(.PROG_CYCLES(PROG_CYCLES), .LOAD_CYCLES(LOAD_CYCLES)) u_seq
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.start_prog(start_prog),
		.start_load(start_load),
		.busy(nvm_busy),
		.copy_to_array(copy_to_array),
		.copy_to_shadow(copy_to_shadow)
	);
	// ----------------------------------------------------------------
	// Shadow registers and nonvolatile array
	// ----------------------------------------------------------------
	reg [7:0] shadow_ff [0:CFG_COUNT-1];
	reg [7:0] array_ff [0:CFG_COUNT-1];
	wire [7:0] cfg_sel = wr_idx - `RBL_IDX_CFG_FIRST;
	integer i;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (i = 0; i < CFG_COUNT; i = i + 1)
			begin
				shadow_ff[i] <= 8'h00;
				array_ff[i] <= 8'h00;
			end
		end
		else
		begin
			for (i = 0; i < CFG_COUNT; i = i + 1)
			begin
				if (copy_to_array)
					array_ff[i] <= shadow_ff[i];
				if (copy_to_shadow)
					shadow_ff[i] <= array_ff[i];
				else if (cfg_wr && (cfg_sel == i[7:0]))
					shadow_ff[i] <= wdata_ff;
			end
		end
	end
	// ----------------------------------------------------------------
	// Read channel and readback latches
	// ----------------------------------------------------------------
	reg [10:0] thermal_ff;
	reg [11:0] current_ff;
	reg [15:0] pwm_ff;
	reg rvalid_ff;
	reg [31:0] rdata_ff;
	reg [1:0] rresp_ff;
	reg [7:0] nxt_rdata;
	reg nxt_rok;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	wire rd_go = s_axi_arvalid && !rvalid_ff;
	wire [7:0] rd_idx = s_axi_araddr[9:2];
	wire [7:0] rd_sel = rd_idx - `RBL_IDX_CFG_FIRST;
	wire rd_cfg = (rd_idx >= `RBL_IDX_CFG_FIRST) && (rd_idx <= `RBL_IDX_CFG_LAST);
	always @*
	begin
		nxt_rdata = 8'h00;
		nxt_rok = 1'b1;
		case (rd_idx)
			`RBL_IDX_TEMP_HIGH: nxt_rdata = {5'h00, thermal_live[10:8]};
			`RBL_IDX_TEMP_LOW: nxt_rdata = thermal_ff[7:0];
			`RBL_IDX_CUR_HIGH: nxt_rdata = {4'h0, current_live[11:8]};
			`RBL_IDX_CUR_LOW: nxt_rdata = current_ff[7:0];
			`RBL_IDX_PWM_HIGH: nxt_rdata = pwm_ff[15:8];
			`RBL_IDX_PWM_LOW: nxt_rdata = pwm_ff[7:0];
			`RBL_IDX_NVM_CTRL: nxt_rdata = {!nvm_busy, 5'h00, cmd_ff};
			`RBL_IDX_UNLOCK: nxt_rdata = 8'h00;
			default:
			begin
				if (rd_cfg)
					nxt_rdata = shadow_ff[rd_sel[4:0]];
				else
					nxt_rok = 1'b0;
			end
		endcase
	end
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `RBL_RESP_OKAY;
		end
		else
		begin
			if (rd_go)
			begin
				rvalid_ff <= 1'b1;
				rdata_ff <= {24'h000000, nxt_rdata};
				rresp_ff <= nxt_rok ? `RBL_RESP_OKAY : `RBL_RESP_SLVERR;
			end
			else if (rvalid_ff && s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// Readback latches
	// ----------------------------------------------------------------
	// A thermal or current high-byte read latches the same word whose top bits it returns
	wire latch_thermal = rd_go && (rd_idx == `RBL_IDX_TEMP_HIGH);
	wire latch_drive = rd_go && (rd_idx == `RBL_IDX_CUR_HIGH);
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			thermal_ff <= 11'h000;
			current_ff <= 12'h000;
			pwm_ff <= `RBL_PWM_RESET;
		end
		else
		begin
			if (latch_thermal)
				thermal_ff <= thermal_live;
			if (latch_drive)
			begin
				current_ff <= current_live;
				pwm_ff <= pwm_live;
			end
		end
	end
endmodule

// >>> tb/rbl_checker.sv
// Bus handshake and nonvolatile control checks on rbl_top ports
`timescale 1ns/1ps
module rbl_checker
#(
	parameter PROG_CYCLES = 20,
	parameter LOAD_CYCLES = 10
)
(
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire nvm_busy,
	input wire unlocked
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
// ----
// Busy length counter
// ----
reg [31:0] cnt_ff;
wire [31:0] nxt_cnt = nvm_busy ? cnt_ff + 32'h1 : 32'h0;
always @(posedge aclk)
	cnt_ff <= aresetn ? nxt_cnt : 32'h0;
a_busy_unlock: assert property ($rose(nvm_busy) |-> $past(unlocked))
	else $error("start while locked");
a_busy_span: assert property ($rose(nvm_busy) |-> nvm_busy[*8])
	else $error("busy too short");
a_busy_len: assert property ($fell(nvm_busy) |->
	(cnt_ff == LOAD_CYCLES || cnt_ff == PROG_CYCLES)) else $error("busy length");
a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
	else $error("rdata upper bits");
a_unlock_cause: assert property ($changed(unlocked) |->
	s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("lock change");
a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
	s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
	s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
a_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("arready with rvalid");
a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
	else $error("write ready with bvalid");
a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("no read answer");
c_busy: cover property ($rose(nvm_busy));
c_unlock: cover property ($rose(unlocked));
c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind rbl_top rbl_checker #(.PROG_CYCLES(PROG_CYCLES), .LOAD_CYCLES(LOAD_CYCLES)) chk_u(.*);

// >>> tb/rbl_live_src.sv
// Far-side source of live thermal, drive current and PWM values
`timescale 1ns/1ps
module rbl_live_src
(
	input wire [15:0] level,
	output wire [10:0] die_thermal,
	output wire [11:0] drive_current,
	output wire [15:0] drive_pwm
);
assign die_thermal = level[10:0];
assign drive_current = ~level[11:0];
assign drive_pwm = {level[7:0], level[15:8]};
endmodule

// >>> tb/rbl_top_tb.sv
// Self-checking bench for the readback latch and nonvolatile control
`timescale 1ns/1ps
module rbl_top_tb;
reg aclk = 1'b0, aresetn = 1'b0;
reg [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
reg [31:0] s_axi_wdata = 32'h0;
reg [3:0] s_axi_wstrb = 4'h0;
reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
reg [15:0] level = 16'h0;
wire [10:0] die_thermal;
wire [11:0] drive_current;
wire [15:0] drive_pwm;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire nvm_busy, unlocked;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
integer err_count = 0, tests_run = 0, i;
reg [31:0] rd_data;
reg [1:0] rd_resp;
// ----
// Rows: op/resp nibble, index, write data, read data
// ----
reg [27:0] tbl [0:35] = '{28'h4190100, 28'h0190080, 28'h4602200, 28'h0600000,
	28'h41A0800, 28'h41ABA00, 28'h41A5500, 28'h41AEF00, 28'h4602200, 28'h0600000,
	28'h41A0800, 28'h41ABA00, 28'h41AEF00, 28'h4190100, 28'h0190001, 28'h8000000,
	28'h0190081, 28'h0600000, 28'h4605A00, 28'h4190000, 28'h4190200, 28'h0190002,
	28'h8000000, 28'h4190000, 28'h4607700, 28'h0600077, 28'h4190100, 28'h8000000,
	28'h4190000, 28'h060005A, 28'h41A3300, 28'h4601100, 28'h060005A, 28'h6150000,
	28'h2400000, 28'h6400000};
always #50 aclk = ~aclk;
rbl_live_src src_u(.*);
rbl_top #(.PROG_CYCLES(20), .LOAD_CYCLES(10)) dut_u(.*);
task chk(input [31:0] g, input [31:0] e);
	tests_run = tests_run + 1;
	if (g !== e)
	begin
		err_count = err_count + 1;
		$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
	end
endtask
task wr(input [7:0] idx, input [7:0] d);
	@(posedge aclk);
	s_axi_awaddr <= {idx, 2'h0};
	s_axi_wdata <= {24'h0, d};
	s_axi_wstrb <= 4'hF;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do
	begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 1'b0;
		if (s_axi_wready) s_axi_wvalid <= 1'b0;
	end
	while (s_axi_bvalid !== 1'b1);
	s_axi_bready <= 1'b0;
	rd_resp = s_axi_bresp;
endtask
task rd(input [7:0] idx);
	@(posedge aclk);
	s_axi_araddr <= {idx, 2'h0};
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do
	begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 1'b0;
	end
	while (s_axi_rvalid !== 1'b1);
	s_axi_rready <= 1'b0;
	rd_data = s_axi_rdata;
	rd_resp = s_axi_rresp;
endtask
task idle_wait;
	repeat (3) @(posedge aclk);
	while (nvm_busy !== 1'b0) @(posedge aclk);
endtask
task rst;
	aresetn <= 1'b0;
	repeat (3) @(posedge aclk);
	aresetn <= 1'b1;
	@(negedge aclk);
	chk(unlocked, 32'h0);
endtask
task conclude;
	$display("Checks run %0d, mismatches %0d", tests_run, err_count);
	if (err_count == 0 && tests_run > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
initial
begin
	rst;
	chk({nvm_busy, s_axi_bvalid, s_axi_rvalid, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h7);
	rd(8'h19);
	chk(rd_data, 32'h80);
	rd(8'h17);
	chk(rd_data, 32'h0);
	rd(8'h18);
	chk(rd_data, 32'h0);
	level <= 16'hD5A3;
	repeat (4) @(posedge aclk);
	rd(8'h13);
	chk(rd_data, 32'h05);
	rd(8'h15);
	chk(rd_data, 32'h0A);
	level <= 16'h2B6E;
	repeat (4) @(posedge aclk);
	rd(8'h14);
	chk(rd_data, 32'hA3);
	rd(8'h16);
	chk(rd_data, 32'h5C);
	rd(8'h17);
	chk(rd_data, 32'hA3);
	rd(8'h18);
	chk(rd_data, 32'hD5);
	rd(8'h13);
	chk(rd_data, 32'h03);
	for (i = 0; i < 36; i = i + 1)
	begin
		case (tbl[i][27:26])
			2'h0: rd(tbl[i][23:16]);
			2'h1: wr(tbl[i][23:16], tbl[i][15:8]);
			default: idle_wait;
		endcase
		if (tbl[i][27:26] == 2'h0) chk(rd_data, tbl[i][7:0]);
		if (tbl[i][27:26] != 2'h2) chk(rd_resp, tbl[i][25:24]);
	end
	chk(unlocked, 32'h0);
	wr(8'h1A, 8'h08);
	wr(8'h1A, 8'hBA);
	wr(8'h1A, 8'hEF);
	chk(unlocked, 32'h1);
	rst;
	rd(8'h19);
	chk(rd_data, 32'h80);
	conclude;
end
initial
begin
	repeat (5000) @(posedge aclk);
	err_count = err_count + 1;
	conclude;
end
endmodule
